// ### rtl/gpb_pkg.sv
`default_nettype none
package gpb_pkg;
  // register offsets on the plain register port
  localparam logic [3:0] GPB_OFF_LATCH = 4'h0;  // output data latch
  localparam logic [3:0] GPB_OFF_DIR   = 4'h1;  // direction register
  localparam int         GPB_WIDTH     = 8;     // pins in the port
  localparam logic [7:0] GPB_DIR_RST   = 8'h00; // all pins input
  localparam int         GPB_SHARED_LO = 6;     // first timer-shared pin
  localparam int         GPB_SHARED_HI = 7;     // second timer-shared pin

  // register port request
  typedef struct packed {
    logic [3:0] addr;  // register offset
    logic [7:0] wdata; // write data
    logic       wr;    // write strobe
    logic       rd;    // read strobe
  } gpb_req_t;

  // pin owner encoding per pin
  typedef enum logic [1:0] {
    GPB_OWN_PORT  = 2'b00, // plain port function
    GPB_OWN_TIMER = 2'b01, // timer channel drives pin
    GPB_OWN_CONV  = 2'b10  // converter samples pin
  } gpb_owner_t;
endpackage
`default_nettype wire

// ### rtl/gpb_sync2.sv
`timescale 1ns/10ps
`default_nettype none
// two-stage synchroniser for a bus of pin levels
module gpb_sync2 #(
  parameter int W = 8 // width of the bus
) (
  input  wire logic         clk_sys, // system clock
  input  wire logic         nrst,    // async reset, active low
  input  wire logic [W-1:0] d,       // asynchronous input
  output logic      [W-1:0] q        // synchronised output
);
  logic [W-1:0] meta; // first stage, read only by q

  // a bus of no bits cannot be synchronised, refuse it at elaboration
  if (W < 1) begin : g_bad_w
    $error("width must be at least one");
  end

  // first stage then second stage, nothing else reads meta
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule
`default_nettype wire

// ### rtl/gpb_port.sv
// What this block does
// - eight pins, each with own latch bit
// - converter beats timer on upper two pins
// - converter selection disconnects enabled timer channel
// - latch write, read back on output pins, unchanged by reset
// - direction one drives latch, zero inputs
// - reset clears all direction bits
//
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
module gpb_port (
  input  wire logic                    clk_sys,    // 25 MHz system clock
  input  wire logic                    nrst,       // async reset, low
  input  wire gpb_pkg::gpb_req_t       req,        // register request
  output logic [7:0]                   rdata,      // read data, next cycle
  input  wire logic [7:0]              pin_in,     // pin levels from pads
  output logic [7:0]                   pin_out,    // pin drive value
  output logic [7:0]                   pin_oe,     // pin drive enable
  input  wire logic [7:0]              conv_sel,   // converter claims pin
  input  wire logic [1:0]              tmr_en,     // timer channel enable
  input  wire logic [1:0]              tmr_oe,     // timer drives its pin
  input  wire logic [1:0]              tmr_out,    // timer output level
  output logic [1:0]                   tmr_in,     // pin level to timer
  output logic [7:0]                   conv_in     // pin level to converter
);
  import gpb_pkg::*;

  logic [7:0] pin_b_output_latch; // data latch, not reset
  logic [7:0] pin_b_direction;    // direction bits
  logic [7:0] pin_sync;           // synchronised pin levels
  logic [7:0] next_rdata;         // read mux result
  logic [1:0] tmr_owns;           // timer owns upper pin
  logic [7:0] drv_en;             // combined drive enable
  logic [7:0] drv_val;            // combined drive value

  // the ports are eight wide and both shared pins must sit inside them
  if (GPB_WIDTH != 8 || GPB_SHARED_HI >= GPB_WIDTH
      || GPB_SHARED_LO >= GPB_SHARED_HI) begin : g_bad_cfg
    $error("shared pin positions do not fit the port");
  end

  gpb_sync2 #(.W(GPB_WIDTH)) u_sync (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .d       (pin_in),
    .q       (pin_sync)
  );

  // latch has no reset so a system reset leaves it alone
  always_ff @(posedge clk_sys) begin
    if (req.wr && req.addr == GPB_OFF_LATCH) begin
      pin_b_output_latch <= req.wdata;
    end
  end

  // direction register, cleared by reset
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pin_b_direction <= GPB_DIR_RST;
    end else if (req.wr && req.addr == GPB_OFF_DIR) begin
      pin_b_direction <= req.wdata;
    end
  end

  // timer holds an upper pin only while converter does not claim it
  always_comb begin
    tmr_owns[0] = tmr_en[0] && !conv_sel[GPB_SHARED_LO];
    tmr_owns[1] = tmr_en[1] && !conv_sel[GPB_SHARED_HI];
  end

  // pin drive: converter pins never driven, timer overrides port
  always_comb begin
    drv_en  = pin_b_direction & ~conv_sel;
    drv_val = pin_b_output_latch;
    if (tmr_owns[0]) begin
      drv_en[GPB_SHARED_LO]  = tmr_oe[0];
      drv_val[GPB_SHARED_LO] = tmr_out[0];
    end
    if (tmr_owns[1]) begin
      drv_en[GPB_SHARED_HI]  = tmr_oe[1];
      drv_val[GPB_SHARED_HI] = tmr_out[1];
    end
  end

  // drive value gated so an undriven pin shows zero
  assign pin_out = drv_val & drv_en;
  assign pin_oe  = drv_en;

  // timer inputs see the pin only while the timer owns it; one assignment
  // so that the output variable keeps a single driver
  assign tmr_in = tmr_owns & {pin_sync[GPB_SHARED_HI],
                              pin_sync[GPB_SHARED_LO]};
  // converter gets the synchronised pin level as analog stand-in only for selected pins
  assign conv_in = pin_sync & conv_sel;

  // read mux; unmapped offsets read zero
  always_comb begin
    next_rdata = 8'h00;
    if (req.addr == GPB_OFF_LATCH) begin
      next_rdata = (pin_b_direction & pin_b_output_latch)
                 | (~pin_b_direction & pin_sync);
    end else if (req.addr == GPB_OFF_DIR) begin
      next_rdata = pin_b_direction;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdata <= 8'h00;
    end else if (req.rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= 8'h00;
    end
  end

  // direction write seen on the pins one cycle later
  property p_dir_drive;
    @(posedge clk_sys) disable iff (!nrst)
      (req.wr && req.addr == GPB_OFF_DIR && conv_sel == 8'h00
       && tmr_en == 2'b00) |=> (pin_oe == $past(req.wdata));
  endproperty
  a_dir_drive: assert property (p_dir_drive)
    else $error("pin enable does not follow direction");

  // a direction read hands back the register, whatever the pins do
  property p_dir_read;
    @(posedge clk_sys) disable iff (!nrst)
      (req.rd && req.addr == GPB_OFF_DIR) |=>
        (rdata == $past(pin_b_direction));
  endproperty
  a_dir_read: assert property (p_dir_read)
    else $error("direction read wrong");

  // converter on pin seven leaves no drive and no timer input there
  property p_conv_wins;
    @(posedge clk_sys) disable iff (!nrst)
      conv_sel[GPB_SHARED_HI] |-> !pin_oe[GPB_SHARED_HI] && !tmr_in[1];
  endproperty
  a_conv_wins: assert property (p_conv_wins)
    else $error("timer still on converter pin");

  // an all-output port reads back the latch, not the pad
  property p_latch_read;
    @(posedge clk_sys) disable iff (!nrst)
      (req.rd && req.addr == GPB_OFF_LATCH && pin_b_direction == 8'hFF)
        |=> rdata == $past(pin_b_output_latch);
  endproperty
  a_latch_read: assert property (p_latch_read)
    else $error("output pin read not from latch");

  // first edge after reset release still sees every pin as input
  property p_reset_dir;
    @(posedge clk_sys) $rose(nrst) |-> pin_b_direction == GPB_DIR_RST;
  endproperty
  a_reset_dir: assert property (p_reset_dir)
    else $error("direction not cleared by reset");

  // a latch write is stored at its strobe edge
  property p_latch_write;
    @(posedge clk_sys) disable iff (!nrst)
      (req.wr && req.addr == GPB_OFF_LATCH) |=>
        pin_b_output_latch == $past(req.wdata);
  endproperty
  a_latch_write: assert property (p_latch_write)
    else $error("latch write lost");

  // converter on pin six with the timer enabled: no drive, no timer input
  property p_timer_cut;
    @(posedge clk_sys) disable iff (!nrst)
      (tmr_en[0] && conv_sel[GPB_SHARED_LO]) |->
        !pin_oe[GPB_SHARED_LO] && !tmr_in[0];
  endproperty
  a_timer_cut: assert property (p_timer_cut)
    else $error("timer not disconnected");

  // quiet port: pins show the latch exactly where direction is one
  property p_eight;
    @(posedge clk_sys) disable iff (!nrst)
      (conv_sel == 8'h00 && tmr_en == 2'b00) |->
        pin_out == (pin_b_output_latch & pin_b_direction);
  endproperty
  a_eight: assert property (p_eight)
    else $error("pin drive differs from latch");

  // timer channel zero alone on pin six, converter away
  sequence s_tmr_lo_alone;
    tmr_en[0] && !conv_sel[GPB_SHARED_LO];
  endsequence

  // converter claims pin six one cycle after the timer held it alone
  sequence s_conv_takes_lo;
    s_tmr_lo_alone ##1 (tmr_en[0] && conv_sel[GPB_SHARED_LO]);
  endsequence

  // an owning timer, not the latch, drives pin six
  property p_tmr_drive;
    @(posedge clk_sys) disable iff (!nrst)
      s_tmr_lo_alone |-> pin_oe[GPB_SHARED_LO] == tmr_oe[0]
        && pin_out[GPB_SHARED_LO] == (tmr_oe[0] && tmr_out[0]);
  endproperty
  a_tmr_drive: assert property (p_tmr_drive)
    else $error("timer does not own its pin");

  // after a takeover the pin level reaches the converter only
  property p_takeover;
    @(posedge clk_sys) disable iff (!nrst)
      s_conv_takes_lo |-> !tmr_in[0]
        && conv_in[GPB_SHARED_LO] == pin_sync[GPB_SHARED_LO];
  endproperty
  a_takeover: assert property (p_takeover)
    else $error("takeover did not reroute the pin");

  // read data stands one cycle only and is zero otherwise
  property p_rdata_idle;
    @(posedge clk_sys) disable iff (!nrst)
      !req.rd |=> rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside its cycle");

  // input pins read back their synchronised pad level
  property p_pin_read;
    @(posedge clk_sys) disable iff (!nrst)
      (req.rd && req.addr == GPB_OFF_LATCH) |=>
        ((rdata ^ $past(pin_sync)) & ~$past(pin_b_direction)) == 8'h00;
  endproperty
  a_pin_read: assert property (p_pin_read)
    else $error("input pin read not from pad");
endmodule
`default_nettype wire

// ### verification/gpb_pads.sv
`timescale 1ns/10ps
`default_nettype none
// pad model: the port drives where enabled, the board drives elsewhere
module gpb_pads (
  input  wire logic [7:0] pin_out, // port drive value
  input  wire logic [7:0] pin_oe,  // port drive enable
  input  wire logic [7:0] ext_lvl, // board level where port is idle
  output logic      [7:0] pin_in   // resolved pad level
);
  // per pin, the enabled buffer wins over the board
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule
`default_nettype wire

// ### verification/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  import gpb_pkg::*;
  logic clk_sys = 1'b0;             // system clock
  logic nrst    = 1'b0;             // reset, active low
  gpb_req_t req = '0;               // register request
  logic [7:0] rdata, pin_in, pin_out, pin_oe, conv_in, ext_lvl = 8'h3C;
  logic [7:0] conv_sel = 8'h00;     // converter claims
  logic [1:0] tmr_en = 2'h0, tmr_oe = 2'h0, tmr_out = 2'h0, tmr_in;
  int bad_count = 0;                // mismatches
  int checks = 0;                   // comparisons
  always #20 clk_sys = ~clk_sys;    // 25 MHz
  gpb_port gpb_port_i (.clk_sys(clk_sys), .nrst(nrst), .req(req),
    .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .conv_sel(conv_sel), .tmr_en(tmr_en), .tmr_oe(tmr_oe),
    .tmr_out(tmr_out), .tmr_in(tmr_in), .conv_in(conv_in));
  gpb_pads gpb_pads_i (.pin_out(pin_out), .pin_oe(pin_oe),
    .ext_lvl(ext_lvl), .pin_in(pin_in));
  // compare and count
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one-cycle write strobe
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    req.wr <= 1'b0;
  endtask
  // one-cycle read strobe, data taken in the following cycle only
  task rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // register paths, pin drive and mixed data read
  task t_regs;
    logic [7:0] v;
    rd(GPB_OFF_DIR, v); chk("dir reset", GPB_DIR_RST, v);
    chk("oe reset", 8'h00, pin_oe);
    wr(GPB_OFF_LATCH, 8'hA5); wr(GPB_OFF_DIR, 8'hFF);   // latch first
    #1 chk("out", 8'hA5, pin_out); chk("oe", 8'hFF, pin_oe);
    rd(GPB_OFF_LATCH, v); chk("latch", 8'hA5, v);
    wr(GPB_OFF_DIR, 8'h0F); repeat (3) @(posedge clk_sys);
    rd(GPB_OFF_LATCH, v); chk("mixed", 8'h35, v);
    rd(GPB_OFF_DIR, v); chk("dir back", 8'h0F, v);
    rd(4'hE, v); chk("unmapped", 8'h00, v);
    $display("test regs done");
  endtask
  // timer on pin six, then converter takes it over with the timer still
  // on: the order is broken on purpose, the port must cut the timer
  task t_share;
    wr(GPB_OFF_DIR, 8'h00); ext_lvl <= 8'hC0;  // board holds 6, 7 high
    @(posedge clk_sys); tmr_en <= 2'h1; tmr_oe <= 2'h1; tmr_out <= 2'h1;
    repeat (3) @(posedge clk_sys); #1 chk("tmr oe", 8'h40, pin_oe);
    chk("tmr out", 8'h40, pin_out);
    chk("tmr in", 8'h01, {6'h00, tmr_in});
    @(posedge clk_sys); conv_sel <= 8'h40;
    repeat (3) @(posedge clk_sys); #1 chk("conv oe", 8'h00, pin_oe);
    chk("cut tmr in", 8'h00, {6'h00, tmr_in});
    chk("conv in", 8'h40, conv_in);
    // pin seven in the kept order: timer off before the converter claims
    @(posedge clk_sys); tmr_en <= 2'h0; tmr_oe <= 2'h0; conv_sel <= 8'h00;
    wr(GPB_OFF_DIR, 8'h80);
    @(posedge clk_sys); conv_sel <= 8'h80;
    @(posedge clk_sys); tmr_en <= 2'h2; tmr_oe <= 2'h2; tmr_out <= 2'h2;
    repeat (3) @(posedge clk_sys); #1 chk("hi oe", 8'h00, pin_oe);
    chk("hi tmr in", 8'h00, {6'h00, tmr_in});
    chk("hi conv in", 8'h80, conv_in);
    @(posedge clk_sys); tmr_en <= 2'h0; tmr_oe <= 2'h0;
    $display("test share done");
  endtask
  // reset mid-run: direction clears, latch keeps its value
  task t_rst;
    @(posedge clk_sys); nrst <= 1'b0; conv_sel <= 8'h00;
    repeat (2) @(posedge clk_sys); nrst <= 1'b1;
    #1 chk("oe rst", 8'h00, pin_oe);
    wr(GPB_OFF_DIR, 8'hFF); #1 chk("kept", 8'hA5, pin_out);
    $display("test reset done");
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    t_regs(); t_share(); t_rst();
    give_verdict();
  end
  // watchdog well beyond the fewer than a hundred cycles the tests need
  initial begin
    #50000;
    bad_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
